// file: rtl/osc_ctrl_pkg.sv
// constants, register layout and types for the oscillator control block
package osc_ctrl_pkg;
   localparam logic [23:0] oscillator_control_addr = 24'hffe0a0;
   localparam logic [23:0] irq_status_addr         = 24'hffe0a1;
   localparam logic [23:0] irq_mask_addr           = 24'hffe0a2;
   localparam logic [23:0] fail_source_addr        = 24'hffe0a3;

   localparam int bit_internal = 7;
   localparam int bit_crystal  = 6;
   localparam int bit_watchdog = 5;
   localparam int bit_pfail    = 4;
   localparam int bit_wfail    = 3;
   localparam int bit_flp      = 2;

   localparam logic [1:0] sel_internal = 2'h0;
   localparam logic [1:0] sel_crystal  = 2'h1;
   localparam logic [1:0] sel_reserved = 2'h2;
   localparam logic [1:0] sel_watchdog = 2'h3;

   // reset value without the option-dependent bit 2
   localparam logic [7:0] osc_ctl_reset = 8'ha0;
   localparam logic [7:0] zero8         = 8'h00;
   localparam logic [1:0] zero2         = 2'h0;
   localparam logic [1:0] irq_pfail     = 2'h1;
   localparam logic [1:0] irq_wfail     = 2'h2;

   // st_sync gives the option synchroniser a second edge before bit 2 is loaded
   typedef enum logic [3:0]
   {
      st_load = 4'h1,
      st_run  = 4'h2,
      st_hold = 4'h4,
      st_sync = 4'h8
   } boot_t;

   typedef struct packed
   {
      logic [23:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

   typedef struct packed
   {
      logic internal_osc_en;
      logic crystal_osc_en;
      logic watchdog_osc_en;
      logic flash_clock_en;
      logic flash_power_en;
      logic [1:0] system_clock_source_select;
   } clk_ctl_t;

   typedef struct packed
   {
      boot_t       boot;
      logic [7:0]  osc_ctl;
      logic [1:0]  status;
      logic [1:0]  mask;
      logic [7:0]  rdata;
      logic        irq;
      clk_ctl_t    ctl;
      logic [1:0]  opt_sync;
      logic [1:0]  pfail_sync;
      logic [1:0]  wfail_sync;
   } state_t;
endpackage

// file: rtl/oscillator_control.sv
// oscillator control register with failure-detect clearing and interrupts
//
// What this block does
// - The internal precision oscillator runs only while bit 7 is one, and bit 7 resets to one.
// - The crystal oscillator is enabled only while bit 6 is one, and bit 6 resets to zero.
// - The watchdog oscillator runs while bit 5 is one and stops when it is cleared; reset is one.
// - Bit 4 arms primary oscillator failure detection and is cleared by hardware on a failure.
// - Bit 3 arms watchdog oscillator failure detection and is cleared by hardware on a failure.
// - Bit 2 is loaded after reset, in st_hold, as the inverse of the low-power option bit.
// - Bits 1:0 pick the system clock: 00 internal, 01 crystal, 11 watchdog, 10 reserved.
`timescale 1ns/10ps
module oscillator_control
   import osc_ctrl_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   input  wire osc_ctrl_pkg::bus_req_t bus,
   output logic [7:0]                rdata,
   output logic                      irq,
   input  wire logic                 low_power_option_bit,
   input  wire logic                 primary_fail,
   input  wire logic                 watchdog_fail,
   input  wire logic                 flash_read,
   output osc_ctrl_pkg::clk_ctl_t    clk_ctl
);
   import osc_ctrl_pkg::*;

   state_t s_reg;
   state_t s_next;

   logic       pfail_event;
   logic       wfail_event;
   logic [7:0] ctl_val;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      s_next = s_reg;
      ctl_val = s_reg.osc_ctl;
      s_next.opt_sync   = {s_reg.opt_sync[0], low_power_option_bit};
      s_next.pfail_sync = {s_reg.pfail_sync[0], primary_fail};
      s_next.wfail_sync = {s_reg.wfail_sync[0], watchdog_fail};
      pfail_event = s_reg.pfail_sync[1] & s_reg.osc_ctl[bit_pfail];
      wfail_event = s_reg.wfail_sync[1] & s_reg.osc_ctl[bit_wfail];
      s_next.rdata = zero8;

      case (s_reg.boot)
         st_load:
         begin
            s_next.boot = st_sync;
         end
         st_sync:
         begin
            // the synchroniser was cleared by reset; its output still holds the reset value and is valid from the next edge, in st_hold
            s_next.boot = st_hold;
         end
         st_hold:
         begin
            ctl_val[bit_flp] = ~s_reg.opt_sync[1];
            s_next.boot = st_run;
         end
         st_run:
         begin
            if (bus.wr && bus.addr == oscillator_control_addr)
            begin
               ctl_val = bus.wdata;
            end
            else if (bus.wr && bus.addr == irq_status_addr)
            begin
               s_next.status = s_reg.status & ~bus.wdata[1:0];
            end
            else if (bus.wr && bus.addr == irq_mask_addr)
            begin
               s_next.mask = bus.wdata[1:0];
            end
         end
         default:
         begin
            s_next.boot = st_load;
         end
      endcase

      if (pfail_event)
      begin
         ctl_val[bit_pfail] = 1'b0;
      end
      if (wfail_event)
      begin
         ctl_val[bit_wfail] = 1'b0;
      end
      // set wins over a same-cycle clear
      s_next.status = s_next.status | (pfail_event ? irq_pfail : zero2)
                                    | (wfail_event ? irq_wfail : zero2);
      s_next.osc_ctl = ctl_val;

      if (bus.rd)
      begin
         if (bus.addr == oscillator_control_addr)
         begin
            s_next.rdata = s_reg.osc_ctl;
         end
         else if (bus.addr == irq_status_addr)
         begin
            s_next.rdata = {6'h00, s_reg.status};
         end
         else if (bus.addr == irq_mask_addr)
         begin
            s_next.rdata = {6'h00, s_reg.mask};
         end
         else if (bus.addr == fail_source_addr)
         begin
            s_next.rdata = {6'h00, s_reg.wfail_sync[1], s_reg.pfail_sync[1]};
         end
         else
         begin
            s_next.rdata = zero8;
         end
      end

      s_next.irq = |(s_next.status & s_next.mask);

      s_next.ctl.internal_osc_en = ctl_val[bit_internal];
      s_next.ctl.crystal_osc_en  = ctl_val[bit_crystal];
      s_next.ctl.watchdog_osc_en = ctl_val[bit_watchdog];
      s_next.ctl.system_clock_source_select = ctl_val[1:0];
      s_next.ctl.flash_clock_en = ~ctl_val[bit_flp] | flash_read;
      s_next.ctl.flash_power_en = ~ctl_val[bit_flp] | flash_read;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg <= '0;
         s_reg.boot <= st_load;
         s_reg.osc_ctl <= osc_ctl_reset;
         s_reg.ctl.internal_osc_en <= 1'b1;
         s_reg.ctl.watchdog_osc_en <= 1'b1;
         s_reg.ctl.flash_clock_en <= 1'b1;
         s_reg.ctl.flash_power_en <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign rdata   = s_reg.rdata;
   assign irq     = s_reg.irq;
   assign clk_ctl = s_reg.ctl;
endmodule

// file: verification/osc_ctrl_monitor.sv
// concurrent checks on the oscillator control ports
`timescale 1ns/10ps
module osc_ctrl_monitor
   import osc_ctrl_pkg::*;
(
   input wire logic                   clock,
   input wire logic                   rst_n,
   input wire osc_ctrl_pkg::bus_req_t bus,
   input wire logic [7:0]             rdata,
   input wire logic                   irq,
   input wire logic                   low_power_option_bit,
   input wire logic                   primary_fail,
   input wire logic                   watchdog_fail,
   input wire logic                   flash_read,
   input wire osc_ctrl_pkg::clk_ctl_t clk_ctl
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire osc_rd = bus.rd && bus.addr == oscillator_control_addr;
   a_int_follow: assert property (osc_rd |=> rdata[7] == clk_ctl.internal_osc_en)
      else $error("internal enable wrong");
   a_xtl_follow: assert property (osc_rd |=> rdata[6] == clk_ctl.crystal_osc_en)
      else $error("crystal enable wrong");
   a_wdt_follow: assert property (osc_rd |=> rdata[5] == clk_ctl.watchdog_osc_en)
      else $error("watchdog enable wrong");
   a_sel_follow: assert property (osc_rd |=> rdata[1:0] == clk_ctl.system_clock_source_select)
      else $error("select wrong");
   a_pfail_clears: assert property (primary_fail [*4] ##0 osc_rd |=> !rdata[4])
      else $error("primary arm not cleared");
   a_wfail_clears: assert property (watchdog_fail [*4] ##0 osc_rd |=> !rdata[3])
      else $error("watchdog arm not cleared");
   a_idle_zero: assert property (!bus.rd |=> rdata == zero8)
      else $error("read data not idle");
   a_unmapped_zero: assert property (bus.rd && bus.addr > fail_source_addr |=> rdata == zero8)
      else $error("unmapped read not zero");
endmodule
bind oscillator_control osc_ctrl_monitor osc_ctrl_monitor_inst (.clock, .rst_n, .bus, .rdata,
   .irq, .low_power_option_bit, .primary_fail, .watchdog_fail, .flash_read, .clk_ctl);

// file: verification/oscillator_control_tb.sv
// self-checking bench for the oscillator control block
`timescale 1ns/10ps
module oscillator_control_tb;
   import osc_ctrl_pkg::*;
   localparam logic [23:0] osc_a = oscillator_control_addr;
   logic       clock = 0;
   logic       rst_n = 0;
   bus_req_t   bus = '0;
   logic [7:0] rdata;
   logic       irq;
   logic       opt = 0;
   logic       pf = 0;
   logic       wf = 0;
   logic       frd = 0;
   clk_ctl_t   cc;
   int         mismatches = 0;
   int         num_checks = 0;
   int         m;
   always #10 clock = ~clock;
   oscillator_control oscillator_control_inst (.clock, .rst_n, .bus, .rdata, .irq,
      .low_power_option_bit(opt), .primary_fail(pf), .watchdog_fail(wf), .flash_read(frd),
      .clk_ctl(cc));
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      num_checks++;
      if (s !== e)
      begin
         $display("wrong value %s expected %h seen %h", n, e, s);
         mismatches++;
      end
   endtask
   task automatic wr(logic [23:0] a, logic [7:0] d);
      @(posedge clock);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      bus <= '0;
   endtask
   task automatic rd(logic [23:0] a, logic [7:0] e, string n);
      @(posedge clock);
      bus <= '{a, 8'h0, 1'b0, 1'b1};
      @(posedge clock);
      bus <= '0;
      #1 chk(n, e, rdata);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      void'($urandom(63));
      for (int i = 0; i < 2; i++)
      begin
         rst_n <= 0;
         opt <= i[0];
         repeat (10) @(posedge clock);
         rst_n <= 1;
         repeat (3) @(posedge clock);
         rd(osc_a, osc_ctl_reset | (i ? 8'h0 : 8'h4), "reset");
      end
      $display("reset test done");
      for (int i = 0; i < 4; i++)
      begin
         m = $urandom & 'hfc | i;
         wr(osc_a, m[7:0]);
         @(posedge clock);
         #1 chk("enables", m[7:0] & 8'he3, {cc.internal_osc_en, cc.crystal_osc_en,
            cc.watchdog_osc_en, 3'h0, cc.system_clock_source_select});
         rd(osc_a, m[7:0], "control");
      end
      $display("select test done");
      for (int i = 0; i < 2; i++)
      begin
         wr(irq_mask_addr, 8'h1);
         wr(osc_a, 8'h18);
         if (i) wf <= 1;
         else pf <= 1;
         repeat (6) @(posedge clock);
         rd(osc_a, 8'h18 & ~(8'h10 >> i), "arm bits");
         chk("irq", {7'h0, !i[0]}, {7'h0, irq});
         rd(fail_source_addr, 8'(1 << i), "fail source");
         rd(irq_status_addr, 8'(1 << i), "status");
         pf <= 0;
         wf <= 0;
         wr(irq_status_addr, 8'h3);
         rd(irq_status_addr, 8'h0, "cleared");
      end
      $display("fail test done");
      wr(osc_a, 8'h84);
      repeat (2) @(posedge clock);
      #1 chk("flash idle", 8'h0, {6'h0, cc.flash_clock_en, cc.flash_power_en});
      frd <= 1;
      repeat (3) @(posedge clock);
      #1 chk("flash read", 8'h3, {6'h0, cc.flash_clock_en, cc.flash_power_en});
      frd <= 0;
      rd(24'hffe0a4, 8'h0, "unmapped");
      $display("flash test done");
      conclude();
   end
   initial
   begin
      #100000;
      mismatches++;
      conclude();
   end
endmodule
